// *** src/efe_regs.svh ***
`ifndef EFE_REGS_SVH
`define EFE_REGS_SVH
// register indices on the serial register port
`define EFE_ENABLE_ADDR       8'h07
`define EFE_FLAGS_ADDR        8'h06
`define EFE_ENABLE_RESET      16'h0040
`define EFE_ENABLE_WMASK      16'h1fff
// flag bit positions (enable bits share the same positions)
`define EFE_BIT_ROM_FAULT     0
`define EFE_BIT_REGMAP_FAULT  1
`define EFE_BIT_IGNORE_FAULT  6
`define EFE_BIT_NEG_RANGE     10
`define EFE_BIT_POS_RANGE     11
`define EFE_BIT_TALLY_ON      12
// periodic register-map check interval
`define EFE_CHECK_PERIOD_US   100
`define EFE_CLK_MHZ           25
`define EFE_CHECK_CYCLES      (`EFE_CHECK_PERIOD_US * `EFE_CLK_MHZ)
`define EFE_ROM_WORDS         8'd16
`endif

// *** src/efe_pkg.sv ***
package efe_pkg;
  typedef enum logic [3:0] {
    EFE_ROM_LOAD  = 4'b0001,
    EFE_ROM_CHECK = 4'b0010,
    EFE_IDLE      = 4'b0100,
    EFE_SCAN      = 4'b1000
  } efe_state_type;
endpackage : efe_pkg

// *** src/efe_crc16.sv ***
`timescale 1ns/1ps
// one step of a crc-16-ccitt over a 16-bit word; clear restarts the code
module efe_crc16 (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clear,
  input  wire logic        step,
  input  wire logic [15:0] word,
  output logic      [15:0] crc
);
  function automatic logic [15:0] efe_crc_word(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ 16'h1021) : (r << 1);
    end
    return r;
  endfunction : efe_crc_word

  logic [15:0] crc_ff;
  wire  [15:0] nxt_crc = clear ? 16'hffff : (step ? efe_crc_word(crc_ff, word) : crc_ff);
  assign crc = crc_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) crc_ff <= 16'hffff;
    else        crc_ff <= nxt_crc;
  end
endmodule : efe_crc16

// *** src/efe_fault_bank.sv ***
`timescale 1ns/1ps
`include "efe_regs.svh"
// What this block does
// - while map check enabled, a check code over config registers is recomputed periodically.
// - flag bit 1 set when the map code changes without a host write.
// - at power-up a check code is computed over ROM words while loading.
// - flag bit 0 set when the ROM code differs from the expected code.
// - flags reset to zero and stay set until the host writes one.
// - every flag except bit 0 is raised only while its enable bit is one; the rom flag is always armed.
// - enable register at 0x07, resets to 0x0040, bits 15..13 read zero.
// - enable bit 12 runs the master-clock tally counter; clearing stops it.
// - enable bit 11 gates positive input range faults; resets disabled.
// - enable bit 10 gates negative input range faults; resets disabled.
// - ignored-access enable resets to one; writes during load or calibration count.
module efe_fault_bank #(
  parameter int unsigned CHECK_CYCLES = `EFE_CHECK_CYCLES,
  parameter logic [15:0] ROM_EXPECTED = 16'h1d0f
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic      [7:0]  rom_addr,
  input  wire logic [15:0] rom_data,
  input  wire logic [15:0] map_word,
  output logic      [7:0]  map_index,
  input  wire logic [7:0]  map_words,
  input  wire logic        calibrating,
  input  wire logic [15:0] fault_events,
  input  wire logic        pos_input_range_event,
  input  wire logic        neg_input_range_event,
  output logic      [15:0] fault_flags,
  output logic      [15:0] fault_enable,
  output logic             master_clock_tally_on,
  output logic             loading
);
  logic [1:0]  rst_sync_ff;
  wire         rst_int_n = rst_sync_ff[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rst_sync_ff <= 2'b00;
    else        rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end

  efe_pkg::efe_state_type state_ff;
  efe_pkg::efe_state_type nxt_state;
  logic [15:0] enable_ff;
  logic [15:0] flags_ff;
  logic [15:0] rdata_ff;
  logic [7:0]  idx_ff;
  logic [31:0] timer_ff;
  logic [15:0] map_ref_ff;
  logic        map_ref_ok_ff;
  logic        map_dirty_ff;

  wire hit_en    = (reg_addr == `EFE_ENABLE_ADDR);
  wire hit_flags = (reg_addr == `EFE_FLAGS_ADDR);
  wire wr_en     = reg_wr && hit_en;
  wire wr_flags  = reg_wr && hit_flags;
  wire in_load   = (state_ff == efe_pkg::EFE_ROM_LOAD) || (state_ff == efe_pkg::EFE_ROM_CHECK);
  wire map_on    = enable_ff[`EFE_BIT_REGMAP_FAULT];
  wire timer_hit = (timer_ff >= CHECK_CYCLES - 1);

  // crc engine shared by the rom check and the periodic map check
  wire         crc_clear = (state_ff == efe_pkg::EFE_IDLE) && timer_hit && map_on;
  wire         crc_step  = (state_ff == efe_pkg::EFE_ROM_LOAD) || (state_ff == efe_pkg::EFE_SCAN);
  wire  [15:0] crc_word  = (state_ff == efe_pkg::EFE_ROM_LOAD) ? rom_data : map_word;
  wire  [15:0] crc_val;

  efe_crc16 u_crc (
    .clk   (clk),
    .rst_n (rst_int_n),
    .clear (crc_clear),
    .step  (crc_step),
    .word  (crc_word),
    .crc   (crc_val)
  );

  wire last_rom  = (idx_ff == `EFE_ROM_WORDS - 8'd1);
  wire last_map  = (idx_ff >= map_words - 8'd1);
  wire scan_done = (state_ff == efe_pkg::EFE_SCAN) && last_map;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      efe_pkg::EFE_ROM_LOAD:  if (last_rom) nxt_state = efe_pkg::EFE_ROM_CHECK;
      efe_pkg::EFE_ROM_CHECK: nxt_state = efe_pkg::EFE_IDLE;
      efe_pkg::EFE_IDLE:      if (crc_clear) nxt_state = efe_pkg::EFE_SCAN;
      efe_pkg::EFE_SCAN:      if (last_map) nxt_state = efe_pkg::EFE_IDLE;
    endcase
  end

  wire [7:0] nxt_idx = (crc_step && !(state_ff == efe_pkg::EFE_ROM_LOAD && last_rom)
                        && !scan_done) ? idx_ff + 8'd1 : 8'd0;

  // raw events; a host write anywhere during a scan poisons that pass
  logic scan_pending_cmp;
  logic cmp_ff;
  assign scan_pending_cmp = cmp_ff && (crc_val != map_ref_ff);
  wire map_changed  = (state_ff == efe_pkg::EFE_IDLE) && map_ref_ok_ff && !map_dirty_ff
                      && scan_pending_cmp;
  wire rom_bad = (state_ff == efe_pkg::EFE_ROM_CHECK) && (crc_val != ROM_EXPECTED);
  wire ignored = reg_wr && (in_load || calibrating);

  logic [15:0] raw_ev;
  always_comb begin
    raw_ev = fault_events;
    raw_ev[`EFE_BIT_ROM_FAULT]    = rom_bad;
    raw_ev[`EFE_BIT_REGMAP_FAULT] = map_changed;
    raw_ev[`EFE_BIT_IGNORE_FAULT] = fault_events[`EFE_BIT_IGNORE_FAULT] | ignored;
    raw_ev[`EFE_BIT_POS_RANGE]    = pos_input_range_event;
    raw_ev[`EFE_BIT_NEG_RANGE]    = neg_input_range_event;
    raw_ev[15:12]                 = 4'h0;
  end

  // the rom check runs before software can touch the enables, so its bit 0 is forced on in the gate
  wire [15:0] gate    = enable_ff | (16'h0001 << `EFE_BIT_ROM_FAULT);
  wire [15:0] set_ev  = raw_ev & gate & `EFE_ENABLE_WMASK;
  wire [15:0] clr_ev  = (wr_flags && !in_load) ? reg_wdata : 16'h0000;
  wire [15:0] nxt_flags = (flags_ff & ~clr_ev) | set_ev;

  wire [15:0] nxt_enable = (wr_en && !in_load && !calibrating)
                           ? (reg_wdata & `EFE_ENABLE_WMASK) : enable_ff;

  wire [15:0] nxt_rdata = hit_en ? enable_ff : (hit_flags ? flags_ff : 16'h0000);

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      state_ff      <= efe_pkg::EFE_ROM_LOAD;
      enable_ff     <= `EFE_ENABLE_RESET;
      flags_ff      <= 16'h0000;
      rdata_ff      <= 16'h0000;
      idx_ff        <= 8'h00;
      timer_ff      <= 32'h0;
      map_ref_ff    <= 16'h0000;
      map_ref_ok_ff <= 1'b0;
      map_dirty_ff  <= 1'b0;
      cmp_ff        <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      enable_ff <= nxt_enable;
      flags_ff  <= nxt_flags;
      rdata_ff  <= reg_rd ? nxt_rdata : rdata_ff;
      idx_ff    <= nxt_idx;
      timer_ff  <= (!map_on || timer_hit) ? 32'h0 : timer_ff + 32'h1;
      cmp_ff    <= scan_done;
      if (cmp_ff) begin
        map_ref_ff    <= crc_val;
        map_ref_ok_ff <= 1'b1;
      end else if (!map_on) begin
        map_ref_ok_ff <= 1'b0;
      end
      // a host write makes the next code legitimately differ
      if (reg_wr && !in_load) map_dirty_ff <= 1'b1;
      else if (cmp_ff)        map_dirty_ff <= 1'b0;
    end
  end

  assign reg_rdata             = rdata_ff;
  assign fault_flags           = flags_ff;
  assign fault_enable          = enable_ff;
  assign master_clock_tally_on = enable_ff[`EFE_BIT_TALLY_ON];
  assign loading               = in_load;
  assign rom_addr              = idx_ff;
  assign map_index             = idx_ff;
endmodule : efe_fault_bank

// *** test/efe_fault_bank_properties.sv ***
`timescale 1ns/1ps
module efe_chk #(
  parameter int unsigned CHECK_CYCLES = 20
) (
  input wire logic        clk, rst_n, reg_wr, reg_rd, calibrating, loading,
  input wire logic        master_clock_tally_on,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata, reg_rdata, fault_flags, fault_enable
);
  // a flag may only drop at an edge where the host wrote a one to it
  logic [15:0] prev_ff;
  logic [15:0] clr_ff;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) {prev_ff, clr_ff} <= 32'h0;
    else {prev_ff, clr_ff} <= {fault_flags, (reg_wr && reg_addr == 8'h06) ? reg_wdata : 16'h0};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_en_wr; reg_wr && reg_addr == 8'h07 && !loading && !calibrating; endsequence
  property p_en_wr; s_en_wr |=> fault_enable == ($past(reg_wdata) & 16'h1fff); endproperty
  a_en_wr: assert property (p_en_wr) else $error("enable write lost");
  property p_rsv; fault_enable[15:13] == 3'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_tally; master_clock_tally_on == fault_enable[12]; endproperty
  a_tally: assert property (p_tally) else $error("tally run wrong");
  property p_pos; $rose(fault_flags[11]) |-> $past(fault_enable[11]); endproperty
  a_pos: assert property (p_pos) else $error("pos range flag ungated");
  property p_neg; $rose(fault_flags[10]) |-> $past(fault_enable[10]); endproperty
  a_neg: assert property (p_neg) else $error("neg range flag ungated");
  property p_map; $rose(fault_flags[1]) |-> $past(fault_enable[1]); endproperty
  a_map: assert property (p_map) else $error("map flag ungated");
  property p_hold; (prev_ff & ~fault_flags & ~clr_ff) == 16'h0; endproperty
  a_hold: assert property (p_hold) else $error("flag dropped");
  property p_rd; reg_rd && reg_addr == 8'h07 |=> reg_rdata == $past(fault_enable); endproperty
  a_rd: assert property (p_rd) else $error("enable read wrong");
  property p_ign; reg_wr && loading && fault_enable[6] |=> fault_flags[6]; endproperty
  a_ign: assert property (p_ign) else $error("ignored write unflagged");
endmodule : efe_chk
bind efe_fault_bank efe_chk #(.CHECK_CYCLES(CHECK_CYCLES)) u_chk (.clk, .rst_n, .reg_wr,
  .reg_rd, .calibrating, .loading, .master_clock_tally_on, .reg_addr, .reg_wdata,
  .reg_rdata, .fault_flags, .fault_enable);

// *** test/efe_far_model.sv ***
`timescale 1ns/1ps
// rom and configuration words; corrupt alters the map as a silent upset would
module efe_far_model (
  input  wire logic [7:0]  rom_addr,
  input  wire logic [7:0]  map_index,
  input  wire logic        corrupt,
  output logic      [15:0] rom_data,
  output logic      [15:0] map_word,
  output logic      [7:0]  map_words
);
  assign rom_data  = {8'h5a, rom_addr};
  assign map_word  = {8'hc3, map_index ^ {7'h00, corrupt}};
  assign map_words = 8'h04;
endmodule : efe_far_model

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic        clk, rst_n, reg_wr, reg_rd, calibrating, corrupt, loading;
  logic        pos_input_range_event, neg_input_range_event, master_clock_tally_on;
  logic [7:0]  reg_addr, rom_addr, map_index, map_words;
  logic [15:0] reg_wdata, reg_rdata, rom_data, map_word, fault_flags, fault_enable;
  int          fail_count, n_compared, cycles;
  efe_fault_bank #(.CHECK_CYCLES(20)) DUT (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .rom_addr, .rom_data, .map_word, .map_index, .map_words,
    .calibrating, .fault_events(16'h0000), .pos_input_range_event, .neg_input_range_event,
    .fault_flags, .fault_enable, .master_clock_tally_on, .loading);
  efe_far_model far (.rom_addr, .map_index, .corrupt, .rom_data, .map_word, .map_words);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // bit 0 is masked: its outcome hangs on the rom code, not on anything driven here
  task automatic rd(input string n, input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(n, reg_rdata & 16'hfffe, e);
  endtask : rd
  initial begin
    {rst_n, reg_wr, reg_rd, calibrating, corrupt} = 5'h00;
    {pos_input_range_event, neg_input_range_event, reg_addr, reg_wdata} = 26'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("loading", {15'h0000, loading}, 16'h0001);
    wr(8'h07, 16'h0000);
    repeat (24) @(posedge clk);
    @(negedge clk);
    chk("loading", {15'h0000, loading}, 16'h0000);
    rd("enable", 8'h07, 16'h0040);
    rd("flags", 8'h06, 16'h0040);
    wr(8'h06, 16'h0000);
    rd("flags", 8'h06, 16'h0040);
    wr(8'h06, 16'h0040);
    rd("flags", 8'h06, 16'h0000);
    wr(8'h07, 16'hffff);
    rd("enable", 8'h07, 16'h1ffe);
    chk("tally", {15'h0000, master_clock_tally_on}, 16'h0001);
    wr(8'h07, 16'h0040);
    @(negedge clk);
    chk("tally", {15'h0000, master_clock_tally_on}, 16'h0000);
    @(posedge clk);
    pos_input_range_event <= 1'b1;
    neg_input_range_event <= 1'b1;
    repeat (3) @(posedge clk);
    rd("flags", 8'h06, 16'h0000);
    wr(8'h07, 16'h0c40);
    rd("flags", 8'h06, 16'h0c00);
    @(posedge clk);
    pos_input_range_event <= 1'b0;
    neg_input_range_event <= 1'b0;
    wr(8'h06, 16'h0c00);
    rd("flags", 8'h06, 16'h0000);
    @(posedge clk);
    calibrating <= 1'b1;
    wr(8'h07, 16'h0000);
    calibrating <= 1'b0;
    rd("enable", 8'h07, 16'h0c40);
    rd("flags", 8'h06, 16'h0040);
    wr(8'h06, 16'hffff);
    wr(8'h07, 16'h0042);
    repeat (100) @(posedge clk);
    rd("flags", 8'h06, 16'h0000);
    @(posedge clk);
    corrupt <= 1'b1;
    repeat (100) @(posedge clk);
    rd("flags", 8'h06, 16'h0002);
    chk("flags out", fault_flags & 16'hfffe, 16'h0002);
    chk("enable out", fault_enable, 16'h0042);
    complete_run();
  end
endmodule : tb_top
